// >>> verilog/csss_pkg.sv
/*
 * Shared constants and types for clock source selection and start-up timing.
 * Assumes fuse codes arrive raw: a fuse bit reads 1 when unprogrammed.
 */
`default_nettype none

package csss_pkg;

    // Counter width for all start-up and delay counts
    localparam int CNT_W = 17;

    // Clock source select fuse codes
    localparam logic [3:0] CK_EXTCLK   = 4'h0;
    localparam logic [3:0] CK_INTRC_LO = 4'h1;
    localparam logic [3:0] CK_INTRC_HI = 4'h4;
    localparam logic [3:0] CK_EXTRC_LO = 4'h5;
    localparam logic [3:0] CK_EXTRC_HI = 4'h8;
    localparam logic [3:0] CK_LFXTAL   = 4'h9;

    // Start-up time fuse codes
    localparam logic [1:0] SUT_C0 = 2'h0;
    localparam logic [1:0] SUT_C1 = 2'h1;
    localparam logic [1:0] SUT_C2 = 2'h2;
    localparam logic [1:0] SUT_C3 = 2'h3;

    // Start-up counts in source cycles, delays in watchdog cycles
    localparam logic [CNT_W-1:0] CNT_ONE  = 17'h00001;
    localparam logic [CNT_W-1:0] SU_6CK   = 17'h00006;
    localparam logic [CNT_W-1:0] SU_18CK  = 17'h00012;
    localparam logic [CNT_W-1:0] SU_1KCK  = 17'h00400;
    localparam logic [CNT_W-1:0] DLY_NONE = 17'h00000;
    localparam logic [CNT_W-1:0] DLY_4K   = 17'h01000;

    // Register offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_TRIM = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_FUSE = 4'h2;
    localparam logic [7:0]        RD_ZERO  = 8'h00;

    // Selected clock source
    typedef enum logic [2:0] {
        SRC_EXTCLK = 3'b000,
        SRC_INTRC  = 3'b001,
        SRC_EXTRC  = 3'b010,
        SRC_LFXTAL = 3'b011,
        SRC_HFXTAL = 3'b100
    } csss_src_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RST_DLY = 2'b00,
        ST_STARTUP = 2'b01,
        ST_RUN     = 2'b10,
        ST_SLEEP   = 2'b11
    } csss_state_t;

    // Fuse fields
    typedef struct packed {
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_source_select_fuses;
    } csss_fuse_t;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } csss_bus_req_t;

    // Status register layout
    typedef struct packed {
        logic        rsvd;
        csss_src_t   src;
        logic [1:0]  range;
        csss_state_t st;
    } csss_stat_t;

endpackage : csss_pkg

`default_nettype wire

// >>> verilog/csss_clock_startup.sv
/*
 * Clock source decode, start-up sequencer and oscillator trim register.
 * Assumes oscillator and watchdog ticks arrive asynchronously on pins and
 * that the fuse, calibration and legacy mode inputs are static.
 */
`timescale 1ns/1ps
`default_nettype none

module csss_clock_startup #(
    parameter logic [csss_pkg::CNT_W-1:0] DLY_LONG_CYC = 17'h10000,
    parameter logic [csss_pkg::CNT_W-1:0] SU_32K_CYC   = 17'h08000
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // Fuses and factory calibration
    input  wire csss_pkg::csss_fuse_t    fuse_i,
    input  wire logic [7:0]              calib_byte_i,
    input  wire logic                    compat_mode_i,
    // Oscillator pins
    input  wire logic                    src_osc_i,
    input  wire logic                    wdt_osc_i,
    // Sleep control from the power manager
    input  wire logic                    deep_sleep_i,
    // Register port
    input  wire csss_pkg::csss_bus_req_t bus_i,
    output logic [7:0]                   rdata_o,
    // Clock generator controls
    output logic                         sys_clk_en_o,
    output csss_pkg::csss_src_t          src_sel_o,
    output logic [1:0]                   rc_range_o,
    output logic [7:0]                   trim_o
);

    csss_pkg::csss_fuse_t        fuse_q;
    csss_pkg::csss_state_t       st_q;
    csss_pkg::csss_src_t         src_q;
    csss_pkg::csss_src_t         src_d;
    logic [1:0]                  range_q;
    logic [1:0]                  range_d;
    logic [csss_pkg::CNT_W-1:0]  cnt_q;
    logic [csss_pkg::CNT_W-1:0]  su_tgt;
    logic [csss_pkg::CNT_W-1:0]  dly_tgt;
    logic [csss_pkg::CNT_W-1:0]  dly_std;
    logic [1:0]                  pin_s1_q;
    logic [1:0]                  pin_s2_q;
    logic [1:0]                  pin_s3_q;
    logic                        src_tick;
    logic                        wdt_tick;
    logic                        clk_en_q;
    logic [7:0]                  trim_q;
    logic [7:0]                  rdata_q;
    logic                        trim_wr;
    csss_pkg::csss_stat_t        stat;

    // Fuse snapshot taken while reset is held
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fuse_q <= fuse_i;
        end
    end

    // Two-stage synchronisers plus edge stage for both oscillator pins
    always_ff @(posedge clk_i) begin
        pin_s1_q <= {wdt_osc_i, src_osc_i};
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
    end

    // Rising edges of the selected source and of the watchdog oscillator
    assign src_tick = pin_s2_q[0] & ~pin_s3_q[0];
    assign wdt_tick = pin_s2_q[1] & ~pin_s3_q[1];

    // Fuse decode into source, range and start-up targets
    always_comb begin
        src_d   = csss_pkg::SRC_HFXTAL;
        range_d = 2'h0;
        su_tgt  = csss_pkg::CNT_ONE;
        dly_tgt = csss_pkg::DLY_NONE;
        if (fuse_q.startup_time_fuses == csss_pkg::SUT_C0) begin
            dly_std = csss_pkg::DLY_NONE;
        end else if (fuse_q.startup_time_fuses == csss_pkg::SUT_C1) begin
            dly_std = csss_pkg::DLY_4K;
        end else begin
            dly_std = DLY_LONG_CYC;
        end
        if (fuse_q.clock_source_select_fuses == csss_pkg::CK_EXTCLK) begin
            src_d   = csss_pkg::SRC_EXTCLK;
            su_tgt  = csss_pkg::SU_6CK;
            dly_tgt = dly_std;
        end else if (fuse_q.clock_source_select_fuses <= csss_pkg::CK_INTRC_HI) begin
            src_d   = csss_pkg::SRC_INTRC;
            range_d = 2'(fuse_q.clock_source_select_fuses - csss_pkg::CK_INTRC_LO);
            su_tgt  = csss_pkg::SU_6CK;
            dly_tgt = dly_std;
        end else if (fuse_q.clock_source_select_fuses <= csss_pkg::CK_EXTRC_HI) begin
            src_d   = csss_pkg::SRC_EXTRC;
            range_d = 2'(fuse_q.clock_source_select_fuses - csss_pkg::CK_EXTRC_LO);
            if (fuse_q.startup_time_fuses == csss_pkg::SUT_C3) begin
                su_tgt  = csss_pkg::SU_6CK;
                dly_tgt = csss_pkg::DLY_4K;
            end else begin
                su_tgt  = csss_pkg::SU_18CK;
                dly_tgt = dly_std;
            end
        end else if (fuse_q.clock_source_select_fuses == csss_pkg::CK_LFXTAL) begin
            src_d = csss_pkg::SRC_LFXTAL;
            if (fuse_q.startup_time_fuses == csss_pkg::SUT_C0) begin
                su_tgt  = csss_pkg::SU_1KCK;
                dly_tgt = csss_pkg::DLY_4K;
            end else if (fuse_q.startup_time_fuses == csss_pkg::SUT_C1) begin
                su_tgt  = csss_pkg::SU_1KCK;
                dly_tgt = DLY_LONG_CYC;
            end else begin
                su_tgt  = SU_32K_CYC;
                dly_tgt = DLY_LONG_CYC;
            end
        end
    end

    // Registered source selection seen by the clock generator
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            src_q   <= csss_pkg::SRC_INTRC;
            range_q <= 2'h0;
        end else begin
            src_q   <= src_d;
            range_q <= range_d;
        end
    end

    // Sequencer: watchdog-timed reset delay, then source-timed start-up
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q     <= csss_pkg::ST_RST_DLY;
            cnt_q    <= csss_pkg::DLY_NONE;
            clk_en_q <= 1'b0;
        end else begin
            case (st_q)
                csss_pkg::ST_RST_DLY: begin
                    if (dly_tgt == csss_pkg::DLY_NONE) begin
                        st_q  <= csss_pkg::ST_STARTUP;
                        cnt_q <= csss_pkg::DLY_NONE;
                    end else if (wdt_tick) begin
                        if (cnt_q == dly_tgt - csss_pkg::CNT_ONE) begin
                            st_q  <= csss_pkg::ST_STARTUP;
                            cnt_q <= csss_pkg::DLY_NONE;
                        end else begin
                            cnt_q <= cnt_q + csss_pkg::CNT_ONE;
                        end
                    end
                end
                csss_pkg::ST_STARTUP: begin
                    if (src_tick) begin
                        if (cnt_q == su_tgt - csss_pkg::CNT_ONE) begin
                            st_q     <= csss_pkg::ST_RUN;
                            cnt_q    <= csss_pkg::DLY_NONE;
                            clk_en_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + csss_pkg::CNT_ONE;
                        end
                    end
                end
                csss_pkg::ST_RUN: begin
                    if (deep_sleep_i) begin
                        st_q     <= csss_pkg::ST_SLEEP;
                        clk_en_q <= 1'b0;
                    end
                end
                default: begin
                    if (!deep_sleep_i) begin
                        st_q  <= csss_pkg::ST_STARTUP;
                        cnt_q <= csss_pkg::DLY_NONE;
                    end
                end
            endcase
        end
    end

    // Trim register: calibration load in reset, software write afterwards
    assign trim_wr = bus_i.wr && (bus_i.addr == csss_pkg::OFS_TRIM)
                     && !compat_mode_i;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            trim_q <= calib_byte_i;
        end else if (trim_wr) begin
            trim_q <= bus_i.wdata;
        end
    end

    // Status word
    assign stat = '{rsvd: 1'b0, src: src_q, range: range_q, st: st_q};

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= csss_pkg::RD_ZERO;
        end else if (!bus_i.rd) begin
            rdata_q <= csss_pkg::RD_ZERO;
        end else if (bus_i.addr == csss_pkg::OFS_TRIM && !compat_mode_i) begin
            rdata_q <= trim_q;
        end else if (bus_i.addr == csss_pkg::OFS_STAT) begin
            rdata_q <= stat;
        end else if (bus_i.addr == csss_pkg::OFS_FUSE) begin
            rdata_q <= {2'h0, fuse_q};
        end else begin
            rdata_q <= csss_pkg::RD_ZERO;
        end
    end

    // Outputs
    assign rdata_o      = rdata_q;
    assign sys_clk_en_o = clk_en_q;
    assign src_sel_o    = src_q;
    assign rc_range_o   = range_q;
    assign trim_o       = trim_q;

    // Checking helpers: independent tick counts per phase
    logic [csss_pkg::CNT_W-1:0] wdt_seen_q;
    logic [csss_pkg::CNT_W-1:0] src_seen_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || st_q != csss_pkg::ST_RST_DLY) begin
            wdt_seen_q <= csss_pkg::DLY_NONE;
        end else if (wdt_tick) begin
            wdt_seen_q <= wdt_seen_q + csss_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || st_q != csss_pkg::ST_STARTUP) begin
            src_seen_q <= csss_pkg::DLY_NONE;
        end else if (src_tick) begin
            src_seen_q <= src_seen_q + csss_pkg::CNT_ONE;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_trim_cal_load: assert property (disable iff (1'b0)
        !reset_n_i ##1 reset_n_i |-> trim_o == $past(calib_byte_i))
        else $error("trim not loaded from calibration");
    a_trim_write_now: assert property (
        bus_i.wr && bus_i.addr == csss_pkg::OFS_TRIM && !compat_mode_i
        |=> trim_o == $past(bus_i.wdata))
        else $error("trim write not applied");
    a_trim_compat_lock: assert property (
        bus_i.wr && compat_mode_i |=> $stable(trim_o))
        else $error("trim changed in legacy mode");
    a_trim_read_back: assert property (
        bus_i.rd && bus_i.addr == csss_pkg::OFS_TRIM && !compat_mode_i
        |=> rdata_o == $past(trim_o) ##1 rdata_o == csss_pkg::RD_ZERO || $past(bus_i.rd))
        else $error("trim read mismatch");
    a_lf_src_select: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses == csss_pkg::CK_LFXTAL
        |-> src_sel_o == csss_pkg::SRC_LFXTAL)
        else $error("watch crystal not selected");
    a_ext_src_select: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses == csss_pkg::CK_EXTCLK
        |-> src_sel_o == csss_pkg::SRC_EXTCLK)
        else $error("external clock not selected");
    a_rc_src_select: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses == csss_pkg::CK_EXTRC_HI
        |-> src_sel_o == csss_pkg::SRC_EXTRC && rc_range_o == 2'h3)
        else $error("external RC range wrong");
    a_int_src_select: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses == csss_pkg::CK_INTRC_LO
        |-> src_sel_o == csss_pkg::SRC_INTRC && rc_range_o == 2'h0)
        else $error("internal RC range wrong");
    a_lf_su_reserved: assert property (
        fuse_q.clock_source_select_fuses == csss_pkg::CK_LFXTAL && fuse_q.startup_time_fuses == csss_pkg::SUT_C3
        |-> su_tgt == SU_32K_CYC && dly_tgt == DLY_LONG_CYC)
        else $error("watch crystal reserved start-up wrong");
    a_rc_su_short: assert property (
        src_d == csss_pkg::SRC_EXTRC && fuse_q.startup_time_fuses == csss_pkg::SUT_C3
        |-> su_tgt == csss_pkg::SU_6CK && dly_tgt == csss_pkg::DLY_4K)
        else $error("external RC short start-up wrong");
    a_int_su_long: assert property (
        src_d == csss_pkg::SRC_INTRC && fuse_q.startup_time_fuses == csss_pkg::SUT_C2
        |-> su_tgt == csss_pkg::SU_6CK && dly_tgt == DLY_LONG_CYC)
        else $error("internal RC start-up wrong");
    a_ext_su_none: assert property (
        src_d == csss_pkg::SRC_EXTCLK && fuse_q.startup_time_fuses == csss_pkg::SUT_C0
        |-> su_tgt == csss_pkg::SU_6CK && dly_tgt == csss_pkg::DLY_NONE)
        else $error("external clock start-up wrong");
    a_rst_delay_len: assert property (
        st_q == csss_pkg::ST_RST_DLY && dly_tgt != csss_pkg::DLY_NONE
        ##1 st_q == csss_pkg::ST_STARTUP |-> $past(wdt_seen_q) == dly_tgt - csss_pkg::CNT_ONE)
        else $error("reset delay length wrong");
    a_startup_len: assert property (
        $rose(sys_clk_en_o) |-> src_seen_q == su_tgt && st_q == csss_pkg::ST_RUN)
        else $error("start-up count wrong");

    // Middle start-up codes, range ends and clock gating
    a_lf_su_mid: assert property (
        fuse_q.clock_source_select_fuses == csss_pkg::CK_LFXTAL && fuse_q.startup_time_fuses == csss_pkg::SUT_C1
        |-> su_tgt == csss_pkg::SU_1KCK && dly_tgt == DLY_LONG_CYC)
        else $error("watch crystal middle start-up wrong");
    a_int_su_mid: assert property (
        src_d == csss_pkg::SRC_INTRC && fuse_q.startup_time_fuses == csss_pkg::SUT_C1
        |-> su_tgt == csss_pkg::SU_6CK && dly_tgt == csss_pkg::DLY_4K)
        else $error("internal RC middle start-up wrong");
    a_hf_src_select: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses > csss_pkg::CK_LFXTAL
        |-> src_sel_o == csss_pkg::SRC_HFXTAL && rc_range_o == 2'h0)
        else $error("high-frequency crystal not selected");
    a_rc_range_lo: assert property (
        $past(reset_n_i) && fuse_q.clock_source_select_fuses == csss_pkg::CK_EXTRC_LO
        |-> src_sel_o == csss_pkg::SRC_EXTRC && rc_range_o == 2'h0)
        else $error("external RC low range wrong");
    a_clk_gated_run: assert property (
        sys_clk_en_o == (st_q == csss_pkg::ST_RUN))
        else $error("system clock enable out of step");

    c_reach_run: cover property ($rose(sys_clk_en_o));
    c_wake_sleep: cover property (st_q == csss_pkg::ST_SLEEP ##1 st_q == csss_pkg::ST_STARTUP);
    c_compat_write: cover property (bus_i.wr && compat_mode_i);
    c_long_delay: cover property (
        st_q == csss_pkg::ST_RST_DLY && dly_tgt == DLY_LONG_CYC ##1 st_q == csss_pkg::ST_STARTUP);
    c_trim_write: cover property (trim_wr);

endmodule : csss_clock_startup

`default_nettype wire

// >>> tb/csss_osc_model.sv
/*
 * Behavioural model of the oscillators outside the block: the selected
 * clock source and the watchdog oscillator, both as slow square waves.
 * Assumes the bench asks for bursts of edges; lines rest low between bursts.
 */
`timescale 1ns/1ps
`default_nettype none

module csss_osc_model (
    // Clock
    input  wire logic clk_i,
    // Oscillator lines
    output var  logic src_osc_o,
    output var  logic wdt_osc_o
);

    // Both lines start at rest
    initial begin
        src_osc_o = 1'b0;
        wdt_osc_o = 1'b0;
    end

    // Makes n rising edges, two cycles high, two low, fixed period
    task automatic pulse(input bit wdt, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (wdt) wdt_osc_o <= 1'b1;
            else src_osc_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            if (wdt) wdt_osc_o <= 1'b0;
            else src_osc_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask : pulse

endmodule : csss_osc_model

`default_nettype wire

// >>> tb/test_clock_source_startup_select.sv
/*
 * Self-checking bench for the clock source decode, start-up sequencer and
 * trim register. Assumes the oscillator model above and shortened long counts.
 */
`timescale 1ns/1ps
`default_nettype none

module test_clock_source_startup_select;

    logic                    clk_i;
    logic                    reset_n_i;
    csss_pkg::csss_fuse_t    fuse_i;
    logic [7:0]              calib_byte_i;
    logic                    compat_mode_i;
    logic                    deep_sleep_i;
    csss_pkg::csss_bus_req_t bus_q;
    logic [7:0]              rdata_o;
    logic                    sys_clk_en_o;
    csss_pkg::csss_src_t     src_sel_o;
    logic [1:0]              rc_range_o;
    logic [7:0]              trim_o;
    wire logic               src_osc;
    wire logic               wdt_osc;
    int                      error_cnt;
    int                      checks;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // Design with shortened long delay and long start-up counts
    csss_clock_startup #(.DLY_LONG_CYC(17'h00040), .SU_32K_CYC(17'h00020)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .fuse_i(fuse_i),
        .calib_byte_i(calib_byte_i), .compat_mode_i(compat_mode_i),
        .src_osc_i(src_osc), .wdt_osc_i(wdt_osc), .deep_sleep_i(deep_sleep_i),
        .bus_i(bus_q), .rdata_o(rdata_o), .sys_clk_en_o(sys_clk_en_o),
        .src_sel_o(src_sel_o), .rc_range_o(rc_range_o), .trim_o(trim_o));

    // Oscillators outside the block
    csss_osc_model osc (.clk_i(clk_i), .src_osc_o(src_osc), .wdt_osc_o(wdt_osc));

    // Compares one value and counts it
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Lets n edges pass, then samples settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_q <= '0;
    endtask : wr

    // One-cycle register read; data stand one cycle only
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_q <= '0;
        #1 check("rdata", rdata_o, exp);
        settle(1);
        check("rdata_idle", rdata_o, 8'h00);
    endtask : rd

    // Resets with new fuses and calibration byte
    task automatic do_reset(input logic [3:0] ck, input logic [1:0] su, input int n);
        @(posedge clk_i);
        reset_n_i    <= 1'b0;
        fuse_i       <= '{startup_time_fuses: su, clock_source_select_fuses: ck};
        calib_byte_i <= {su, 2'h1, ck};
        deep_sleep_i <= 1'b0;
        settle(n);
        check("en_rst", sys_clk_en_o, 8'h00);
        check("src_rst", src_sel_o, 8'h01);
        check("trim_rst", trim_o, {su, 2'h1, ck});
        @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask : do_reset

    // Checks start-up right at the edge count boundary, then sleep and wake
    task automatic run_case(input logic [3:0] ck, input logic [1:0] su,
                            input csss_pkg::csss_src_t src, input logic [1:0] rg,
                            input int nsrc, input int ndly);
        logic [5:0] stat;
        stat = {1'b0, src, rg};
        do_reset(ck, su, 4);
        settle(2);
        check("src_sel", src_sel_o, src);
        check("rc_range", rc_range_o, rg);
        rd(csss_pkg::OFS_FUSE, {2'h0, su, ck});
        rd(csss_pkg::OFS_STAT, {stat, (ndly > 0) ? 2'h0 : 2'h1});
        if (ndly > 0) begin
            osc.pulse(1'b1, ndly - 1);
            osc.pulse(1'b0, nsrc);
            settle(8);
            check("en_dly", sys_clk_en_o, 8'h00);
            osc.pulse(1'b1, 1);
            settle(8);
        end
        for (int w = 0; w < 2; w++) begin
            osc.pulse(1'b0, nsrc - 1);
            settle(8);
            check("en_early", sys_clk_en_o, 8'h00);
            osc.pulse(1'b0, 1);
            settle(8);
            check("en_run", sys_clk_en_o, 8'h01);
            rd(csss_pkg::OFS_STAT, {stat, 2'h2});
            if (w == 0) begin
                @(posedge clk_i);
                deep_sleep_i <= 1'b1;
                settle(3);
                check("en_sleep", sys_clk_en_o, 8'h00);
                rd(csss_pkg::OFS_STAT, {stat, 2'h3});
                @(posedge clk_i);
                deep_sleep_i <= 1'b0;
            end
        end
    endtask : run_case

    // Cuts a hang short
    initial begin
        repeat (95000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        clk_i = 1'b0;
        reset_n_i = 1'b0;
        fuse_i = '1;
        calib_byte_i = 8'h00;
        compat_mode_i = 1'b0;
        deep_sleep_i = 1'b0;
        bus_q = '0;
        error_cnt = 0;
        checks = 0;
        do_reset(4'h1, 2'h2, 20);
        run_case(4'h9, 2'h0, csss_pkg::SRC_LFXTAL, 2'h0, 1024, 4096);
        run_case(4'h9, 2'h1, csss_pkg::SRC_LFXTAL, 2'h0, 1024, 64);
        run_case(4'h9, 2'h2, csss_pkg::SRC_LFXTAL, 2'h0, 32, 64);
        run_case(4'h9, 2'h3, csss_pkg::SRC_LFXTAL, 2'h0, 32, 64);
        run_case(4'h5, 2'h0, csss_pkg::SRC_EXTRC, 2'h0, 18, 0);
        run_case(4'h6, 2'h2, csss_pkg::SRC_EXTRC, 2'h1, 18, 64);
        run_case(4'h8, 2'h3, csss_pkg::SRC_EXTRC, 2'h3, 6, 4096);
        run_case(4'h1, 2'h2, csss_pkg::SRC_INTRC, 2'h0, 6, 64);
        run_case(4'h2, 2'h1, csss_pkg::SRC_INTRC, 2'h1, 6, 4096);
        run_case(4'h3, 2'h0, csss_pkg::SRC_INTRC, 2'h2, 6, 0);
        run_case(4'h4, 2'h3, csss_pkg::SRC_INTRC, 2'h3, 6, 64);
        run_case(4'h0, 2'h3, csss_pkg::SRC_EXTCLK, 2'h0, 6, 64);
        run_case(4'h0, 2'h0, csss_pkg::SRC_EXTCLK, 2'h0, 6, 0);
        run_case(4'ha, 2'h0, csss_pkg::SRC_HFXTAL, 2'h0, 1, 0);
        // Reset loads the calibration byte; software then writes 00, 7f and ff and reads each back
        rd(csss_pkg::OFS_TRIM, 8'h1a);
        for (int i = 0; i < 3; i++) begin
            wr(csss_pkg::OFS_TRIM, (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'hff);
            #1 check("trim_now", trim_o, (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'hff);
            rd(csss_pkg::OFS_TRIM, (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'hff);
        end
        // Read-only and unmapped places ignore writes
        wr(csss_pkg::OFS_STAT, 8'h00);
        rd(csss_pkg::OFS_STAT, 8'h42);
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00);
        check("trim_keep", trim_o, 8'hff);
        // Legacy mode hides the trim register
        @(posedge clk_i);
        compat_mode_i <= 1'b1;
        wr(csss_pkg::OFS_TRIM, 8'h33);
        settle(1);
        check("trim_hidden", trim_o, 8'hff);
        rd(csss_pkg::OFS_TRIM, 8'h00);
        @(posedge clk_i);
        compat_mode_i <= 1'b0;
        rd(csss_pkg::OFS_TRIM, 8'hff);
        print_verdict();
    end

endmodule : test_clock_source_startup_select

`default_nettype wire
